// file: sim/peer_axis_model.sv
/*
  peer axis controller on another board: pulls the shared start or stop
  line low for a few cycles whenever the bench asks for it.
  assumes wired-low lines with pull-ups resolved by the bench.
*/
`timescale 1ns/10ps
module peer_axis_model #(
  parameter int HOLD = 4
) (
  input wire logic ref_clk, // controller clock
  input wire logic rst, // async reset, active high
  input wire logic pull_start, // request a start pulse, one cycle
  input wire logic pull_stop, // request a stop pulse, one cycle
  output logic start_oe_n, // low while pulling the start line
  output logic stop_oe_n // low while pulling the stop line
);
  // ========================================================================
  // line drivers
  logic [7:0] start_cnt_q;
  logic [7:0] stop_cnt_q;

  // held for several cycles so two-flop synchronisers on every board see it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      start_cnt_q <= 8'h00;
      stop_cnt_q <= 8'h00;
    end
    else
    begin
      start_cnt_q <= pull_start ? 8'(HOLD) : (start_cnt_q != 8'h00 ? start_cnt_q - 8'h01 : 8'h00);
      stop_cnt_q <= pull_stop ? 8'(HOLD) : (stop_cnt_q != 8'h00 ? stop_cnt_q - 8'h01 : 8'h00);
    end
  end

  // released lines float up through the pull-up, never hold the last value
  assign start_oe_n = (start_cnt_q == 8'h00);
  assign stop_oe_n = (stop_cnt_q == 8'h00);
endmodule

// file: sim/tb.sv
/*
  self-checking bench for the simultaneous start/stop block: register
  tasks, one peer board on the shared lines, and a verdict.
  assumes the package register map and pull-ups on both shared lines.
*/
`timescale 1ns/10ps
module tb;
  localparam int PC = 2;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] axis_busy = 4'h0;
  logic [3:0] alarm = 4'h0;
  logic [3:0] limit = 4'h0;
  logic [3:0] start_pulse, stop_now, stop_ramp, seen;
  logic sta_out, sta_oe_n, stp_out, stp_oe_n, irq, peer_sta_oe_n, peer_stp_oe_n;
  logic pull_start = 1'b0;
  logic pull_stop = 1'b0;
  int fails = 0;
  int n_compared = 0;

  // ========================================================================
  // wired-low shared lines, high when nobody pulls
  wire start_line_n = !((!sta_oe_n && !sta_out) || !peer_sta_oe_n);
  wire stop_line_n = !((!stp_oe_n && !stp_out) || !peer_stp_oe_n);

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  multi_axis_sync_start_stop #(.N(4), .PULSE_CYC(PC)) dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .axis_busy(axis_busy),
    .drive_alarm_input(alarm), .end_limit_input(limit), .start_pulse(start_pulse), .stop_now(stop_now),
    .stop_ramp(stop_ramp), .shared_start_line_in_n(start_line_n), .shared_start_line_out(sta_out),
    .shared_start_line_oe_n(sta_oe_n), .shared_stop_line_in_n(stop_line_n), .shared_stop_line_out(stp_out),
    .shared_stop_line_oe_n(stp_oe_n), .irq(irq));

  peer_axis_model #(.HOLD(4)) peer (.ref_clk(ref_clk), .rst(rst), .pull_start(pull_start),
    .pull_stop(pull_stop), .start_oe_n(peer_sta_oe_n), .stop_oe_n(peer_stp_oe_n));

  // ========================================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name,
    input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata & m);
  endtask

  task automatic set_cfg(input int ax, input logic [8:0] c);
    wr_reg(sync_pkg::CFG_BASE + 8'(4 * ax), {23'h0, c});
  endtask

  // bounded wait: 0 start pulses, 1 stop pulses, 2 own stop line drive
  task automatic wait_ev(input int sel, input int lim);
    seen = 4'h0;
    // look first in the cycle the caller is in: a pulse may stand there already
    for (int i = 0; i < lim && seen == 4'h0; i++)
    begin
      #1;
      seen = (sel == 0) ? start_pulse : (sel == 1 ? (stop_now | stop_ramp) : {3'h0, ~stp_oe_n});
      if (seen == 4'h0)
        @(posedge ref_clk);
    end
  endtask

  task automatic pulse_peer(input bit stop);
    @(posedge ref_clk);
    if (stop) pull_stop <= 1'b1;
    else pull_start <= 1'b1;
    @(posedge ref_clk);
    pull_stop <= 1'b0;
    pull_start <= 1'b0;
  endtask

  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #500000;
    fails++;
    summarize();
  end

  // ========================================================================
  // test sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(sync_pkg::CFG_BASE, 32'h0, "cfg0 reset");
    rd_chk(sync_pkg::IRQ_MASK_ADDR, 32'h0, "irq mask reset");
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0, "unmapped read");
    chk("stop drive reset", 32'h1, {31'h0, stp_oe_n});
    $display("test reset done");
    // type 0 starts at once; start event raises the interrupt
    wr_reg(sync_pkg::IRQ_MASK_ADDR, 32'h0000_000F);
    wr_reg(sync_pkg::CMD_ADDR, 32'h1);
    wait_ev(0, 3);
    chk("type0 start", 32'h1, {28'h0, seen});
    @(posedge ref_clk);
    #1;
    chk("start one cycle", 32'h0, {28'h0, start_pulse});
    chk("irq on start", 32'h1, {31'h0, irq});
    rd_chk(sync_pkg::IRQ_STAT_ADDR, 32'h1, "irq status");
    rd_chk(sync_pkg::IRQ_STAT_ADDR, 32'h0, "irq status cleared");
    chk("irq cleared", 32'h0, {31'h0, irq});
    // reserved type 2 never starts
    set_cfg(1, 9'h080);
    wr_reg(sync_pkg::CMD_ADDR, 32'h2);
    wait_ev(0, 6);
    chk("reserved type", 32'h0, {28'h0, seen});
    $display("test immediate done");
    // type 1 holds until a peer asserts the start line
    set_cfg(0, 9'h040);
    set_cfg(1, 9'h040);
    wr_reg(sync_pkg::CMD_ADDR, 32'h3);
    rd_chk(sync_pkg::STATUS_ADDR, 32'h3, "waiting", 32'hF);
    wait_ev(0, 6);
    chk("held for start", 32'h0, {28'h0, seen});
    pulse_peer(1'b0);
    wait_ev(0, 8);
    chk("start together", 32'h3, {28'h0, seen});
    rd_chk(sync_pkg::STATUS_ADDR, 32'h0, "waiting cleared", 32'hF);
    // group start: wrong lead refused, right lead drives the line
    set_cfg(2, 9'h040);
    wr_reg(sync_pkg::GROUP_ADDR, 32'h4);
    wr_reg(sync_pkg::CMD_ADDR, 32'h4);
    wr_reg(sync_pkg::CMD_ADDR, 32'h0000_0010);
    @(posedge ref_clk);
    #1;
    chk("wrong lead drive", 32'h1, {31'h0, sta_oe_n});
    wr_reg(sync_pkg::CMD_ADDR, 32'h0000_0210);
    @(posedge ref_clk);
    #1;
    chk("group drive", 32'h0, {31'h0, sta_oe_n});
    wait_ev(0, 8);
    chk("group start", 32'h4, {28'h0, seen});
    chk("drive released", 32'h1, {31'h0, sta_oe_n});
    $display("test group start done");
    // type 3: mask 5 needs both axes 0 and 2 stopped
    @(posedge ref_clk);
    axis_busy <= 4'h5;
    set_cfg(3, 9'h0C5);
    wr_reg(sync_pkg::CMD_ADDR, 32'h8);
    wait_ev(0, 5);
    chk("mask5 held", 32'h0, {28'h0, seen});
    @(posedge ref_clk) axis_busy <= 4'h4;
    wait_ev(0, 5);
    chk("one of two stopped", 32'h0, {28'h0, seen});
    @(posedge ref_clk) axis_busy <= 4'h0;
    wait_ev(0, 5);
    chk("both stopped", 32'h8, {28'h0, seen});
    // each single mask bit selects its own axis; zero means no stand-by
    for (int b = 0; b < 5; b++)
    begin
      @(posedge ref_clk);
      axis_busy <= 4'hF;
      set_cfg(3, 9'h0C0 | 9'((b < 4) ? (1 << b) : 0));
      wr_reg(sync_pkg::CMD_ADDR, 32'h8);
      wait_ev(0, 4);
      chk("mask wait", (b < 4) ? 32'h0 : 32'h8, {28'h0, seen});
      @(posedge ref_clk) axis_busy <= 4'hF & ~(4'h1 << b);
      if (b < 4) wait_ev(0, 5);
      if (b < 4) chk("mask bit start", 32'h8, {28'h0, seen});
    end
    $display("test axis wait done");
    // stop line: axis 0 halts at once, axis 1 ramps, 2 and 3 ignore it
    @(posedge ref_clk);
    axis_busy <= 4'hF;
    wr_reg(sync_pkg::GROUP_ADDR, 32'h0);
    set_cfg(0, 9'h010);
    set_cfg(1, 9'h110);
    set_cfg(2, 9'h000);
    set_cfg(3, 9'h000);
    pulse_peer(1'b1);
    wait_ev(1, 8);
    chk("stop set", 32'h3, {28'h0, seen});
    chk("stop now", 32'h1, {28'h0, stop_now});
    chk("stop ramp", 32'h2, {28'h0, stop_ramp});
    wr_reg(sync_pkg::GROUP_ADDR, 32'h3);
    wr_reg(sync_pkg::CMD_ADDR, 32'h20);
    wait_ev(1, 8);
    chk("group stop", 32'h3, {28'h0, seen});
    $display("test stop done");
    // abnormal stop drives the stop line only where enabled
    set_cfg(3, 9'h020);
    rd_chk(sync_pkg::IRQ_STAT_ADDR, 32'h0, "irq drain", 32'h0);
    wr_reg(sync_pkg::IRQ_MASK_ADDR, 32'h80);
    limit <= 4'h4;
    wait_ev(2, 6);
    chk("no auto drive", 32'h0, {28'h0, seen});
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge ref_clk) alarm <= 4'h8;
    wait_ev(2, 6);
    chk("auto drive", 32'h1, {28'h0, seen});
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_chk(sync_pkg::IRQ_STAT_ADDR, 32'hC0, "abnormal events", 32'hF0);
    chk("irq read clear", 32'h0, {31'h0, irq});
    @(posedge ref_clk);
    alarm <= 4'h0;
    limit <= 4'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("auto drive released", 32'h1, {31'h0, stp_oe_n});
    $display("test abnormal stop done");
    summarize();
  end
endmodule

// file: verilog/axis_sync_ctrl.sv
/*
  per-axis start/stop decision: holds a loaded move until its start
  condition holds, turns stop requests into halt pulses, flags faults.
  assumes stop and start requests arrive already synchronised.
*/
`timescale 1ns/10ps
module axis_sync_ctrl #(
  parameter int N = 4
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state while low
  input wire sync_pkg::axis_cfg_type cfg, // axis options
  input wire logic op_cmd, // operation command written, one cycle
  input wire logic group_go, // shared start line asserted, synchronised
  input wire logic stop_req, // stop request for this axis
  input wire logic [N-1:0] stopped, // axes currently stopped
  input wire logic axis_busy, // motion core is outputting pulses
  input wire logic fault, // alarm or end limit active
  output logic start_pulse, // begin motion, one cycle
  output logic stop_now, // immediate halt, high the cycle after each cycle of stop_hit while stop_mode is 0
  output logic stop_ramp, // decelerate to halt, high the cycle after each cycle of stop_hit while stop_mode is 1
  output logic waiting, // move loaded and held
  output logic fault_stop, // abnormal stop event, one cycle
  output logic drive_stop // this axis pulls the stop line
);

  sync_pkg::axis_state_type state_q;
  logic axes_done;
  logic start_d;
  logic stop_hit;
  logic fault_q;

  // every selected axis must be stopped; an empty mask is met at once
  assign axes_done = (cfg.wait_mask & stopped) == cfg.wait_mask;
  assign stop_hit = stop_req && (axis_busy || state_q != sync_pkg::idle_st);
  assign waiting = state_q != sync_pkg::idle_st;

  // start decision
  always_comb
  begin
    start_d = 1'b0;
    unique case (state_q)
      sync_pkg::idle_st: start_d = op_cmd && (cfg.start_type == sync_pkg::START_NOW
        || (cfg.start_type == sync_pkg::START_AXES && axes_done));
      sync_pkg::wait_start_st: start_d = group_go && !stop_req;
      sync_pkg::wait_axes_st: start_d = axes_done && !stop_req;
    endcase
  end

  // hold state; reserved start type drops the command
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state_q <= sync_pkg::idle_st;
    else if (ce)
    begin
      unique case (state_q)
        sync_pkg::idle_st:
          if (op_cmd && cfg.start_type == sync_pkg::START_GROUP)
            state_q <= sync_pkg::wait_start_st;
          else if (op_cmd && cfg.start_type == sync_pkg::START_AXES && !axes_done)
            state_q <= sync_pkg::wait_axes_st;
        sync_pkg::wait_start_st, sync_pkg::wait_axes_st:
          if (stop_req || start_d)
            state_q <= sync_pkg::idle_st;
      endcase
    end
  end

  // start and halt pulses
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      start_pulse <= 1'b0;
      stop_now <= 1'b0;
      stop_ramp <= 1'b0;
    end
    else if (ce)
    begin
      start_pulse <= start_d;
      stop_now <= stop_hit && !cfg.stop_mode;
      stop_ramp <= stop_hit && cfg.stop_mode;
    end
  end

  // fault edge while moving; line held until the fault clears
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_q <= 1'b0;
      fault_stop <= 1'b0;
      drive_stop <= 1'b0;
    end
    else if (ce)
    begin
      fault_q <= fault;
      fault_stop <= fault && !fault_q && axis_busy;
      if (!fault)
        drive_stop <= 1'b0;
      else if (!fault_q && axis_busy && cfg.auto_stop_out)
        drive_stop <= 1'b1;
    end
  end

  start_now_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_q == sync_pkg::idle_st && op_cmd && cfg.start_type == sync_pkg::START_NOW |=> start_pulse)
    else $error("immediate start missing");
  wait_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_q == sync_pkg::wait_start_st && !group_go |=> !start_pulse)
    else $error("start without group start");
  mask_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_q == sync_pkg::wait_axes_st && !axes_done && !stop_req |=> !start_pulse && waiting)
    else $error("started before selected axes stopped");
  stop_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && stop_hit |=> (stop_now != stop_ramp) && (stop_ramp == $past(cfg.stop_mode)))
    else $error("stop style wrong");
  drive_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && $past(ce) && drive_stop |-> $past(fault) && ($past(drive_stop) || $past(cfg.auto_stop_out)))
    else $error("stop line driven without fault");
  cover_wait_start_c: cover property (@(posedge ref_clk) state_q == sync_pkg::wait_start_st ##1 start_pulse);
  cover_fault_c: cover property (@(posedge ref_clk) fault_stop ##1 drive_stop);

endmodule

// file: verilog/multi_axis_sync_start_stop.sv
/*
  multi-axis simultaneous start/stop logic: option registers, group
  commands, shared open-drain start/stop lines and an interrupt.
  assumes peer boards share the lines wired-low and a plain register port.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
module multi_axis_sync_start_stop #(
  parameter int N = sync_pkg::NUM_AXES,
  parameter int PULSE_CYC = sync_pkg::LINE_PULSE_CYC
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic [sync_pkg::ADDR_W-1:0] addr, // register byte address
  input wire logic [sync_pkg::DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [sync_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
  input wire logic [N-1:0] axis_busy, // per-axis motion active
  input wire logic [N-1:0] drive_alarm_input, // drive alarm, active high
  input wire logic [N-1:0] end_limit_input, // end limit reached, active high
  output logic [N-1:0] start_pulse, // begin motion, one cycle
  output logic [N-1:0] stop_now, // immediate halt
  output logic [N-1:0] stop_ramp, // decelerating halt
  input wire logic shared_start_line_in_n, // shared start line level
  output logic shared_start_line_out, // driven level, always low
  output logic shared_start_line_oe_n, // low while pulling the line
  input wire logic shared_stop_line_in_n, // shared stop line level
  output logic shared_stop_line_out, // driven level, always low
  output logic shared_stop_line_oe_n, // low while pulling the line
  output logic irq // level interrupt
);

  localparam int CW = $clog2(PULSE_CYC + 1);

  sync_pkg::axis_cfg_type cfg_q [N];
  logic [3:0] member_q;
  logic [sync_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sync_pkg::IRQ_W-1:0] irq_mask_q;
  logic [sync_pkg::IRQ_W-1:0] irq_evt;
  logic start_meta_q, start_sync_q, stop_meta_q, stop_sync_q;
  logic [CW-1:0] start_cnt_q, stop_cnt_q;
  logic [N-1:0] waiting, fault_stop, drive_stop, op_cmd, stop_req;
  logic gcmd_ok, gstart_cmd, gstop_cmd;

  // lowest set bit of a member mask, the group's lead axis
  function automatic logic [1:0] lead_of(input logic [3:0] m);
    lead_of = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

  // number of members, shown to software
  function automatic logic [2:0] count_of(input logic [3:0] m);
    count_of = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  // ==========================================================================
  // command decode
  // group commands only act when addressed by the lowest member axis
  assign gcmd_ok = wr && addr == sync_pkg::CMD_ADDR && member_q != 4'h0
    && wdata[sync_pkg::CMD_LEAD_LSB +: 2] == lead_of(member_q);
  assign gstart_cmd = gcmd_ok && wdata[sync_pkg::CMD_GSTART_BIT];
  assign gstop_cmd = gcmd_ok && wdata[sync_pkg::CMD_GSTOP_BIT];
  assign op_cmd = (wr && addr == sync_pkg::CMD_ADDR) ? wdata[sync_pkg::CMD_OP_LSB +: N] : '0;

  // ==========================================================================
  // option and group registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < N; i++)
        cfg_q[i] <= sync_pkg::CFG_RESET;
      member_q <= sync_pkg::GROUP_RESET;
    end
    else if (ce && wr)
    begin
      for (int i = 0; i < N; i++)
        if (addr == sync_pkg::CFG_BASE + 8'(4 * i))
          cfg_q[i] <= wdata[sync_pkg::CFG_W-1:0];
      if (addr == sync_pkg::GROUP_ADDR)
        member_q <= wdata[3:0];
    end
  end

  // ==========================================================================
  // shared line synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      start_meta_q <= 1'b0;
      start_sync_q <= 1'b0;
      stop_meta_q <= 1'b0;
      stop_sync_q <= 1'b0;
    end
    else if (ce)
    begin
      start_meta_q <= !shared_start_line_in_n;
      start_sync_q <= start_meta_q;
      stop_meta_q <= !shared_stop_line_in_n;
      stop_sync_q <= stop_meta_q;
    end
  end

  // ==========================================================================
  // line drivers; our own commands go out on the lines so that local axes
  // and peer boards see the same synchronised edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      start_cnt_q <= '0;
      stop_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (gstart_cmd)
        start_cnt_q <= CW'(PULSE_CYC);
      else if (start_cnt_q != '0)
        start_cnt_q <= start_cnt_q - CW'(1);
      if (gstop_cmd)
        stop_cnt_q <= CW'(PULSE_CYC);
      else if (stop_cnt_q != '0)
        stop_cnt_q <= stop_cnt_q - CW'(1);
    end
  end

  // open-drain: only the enable moves, the level is always low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shared_start_line_oe_n <= 1'b1;
      shared_stop_line_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      shared_start_line_oe_n <= !(gstart_cmd || start_cnt_q > CW'(1));
      shared_stop_line_oe_n <= !(gstop_cmd || stop_cnt_q > CW'(1) || |drive_stop);
    end
  end
  assign shared_start_line_out = 1'b0;
  assign shared_stop_line_out = 1'b0;

  // ==========================================================================
  // per-axis controllers; all see the same synchronised line level
  for (genvar g = 0; g < N; g++)
  begin : axis
    // members halt on the group stop; others only if they listen to the line
    assign stop_req[g] = stop_sync_q && (cfg_q[g].stop_enable || member_q[g]);
    axis_sync_ctrl #(.N(N)) ctrl (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .cfg(cfg_q[g]),
      .op_cmd(op_cmd[g]),
      .group_go(start_sync_q),
      .stop_req(stop_req[g]),
      .stopped(~axis_busy),
      .axis_busy(axis_busy[g]),
      .fault(drive_alarm_input[g] || end_limit_input[g]),
      .start_pulse(start_pulse[g]),
      .stop_now(stop_now[g]),
      .stop_ramp(stop_ramp[g]),
      .waiting(waiting[g]),
      .fault_stop(fault_stop[g]),
      .drive_stop(drive_stop[g])
    );
  end

  // ==========================================================================
  // interrupt: sticky events, read of status clears, new events win
  assign irq_evt = {fault_stop, start_pulse};
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_stat_q <= '0;
    else if (ce)
    begin
      if (rd && addr == sync_pkg::IRQ_STAT_ADDR)
        irq_stat_q <= irq_evt;
      else
        irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_mask_q <= sync_pkg::IRQ_MASK_RESET;
    else if (ce && wr && addr == sync_pkg::IRQ_MASK_ADDR)
      irq_mask_q <= wdata[sync_pkg::IRQ_W-1:0];
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================================
  // read port; unmapped addresses read zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= '0;
    else if (ce)
    begin
      rdata <= '0;
      if (rd)
      begin
        for (int i = 0; i < N; i++)
          if (addr == sync_pkg::CFG_BASE + 8'(4 * i))
            rdata <= 32'(cfg_q[i]);
        unique case (addr)
          sync_pkg::GROUP_ADDR: rdata <= 32'(member_q);
          sync_pkg::STATUS_ADDR:
          begin
            rdata[sync_pkg::ST_WAIT_LSB +: N] <= waiting;
            rdata[sync_pkg::ST_BUSY_LSB +: N] <= axis_busy;
            rdata[sync_pkg::ST_DRIVE_LSB +: N] <= drive_stop;
            rdata[sync_pkg::ST_START_BIT] <= start_sync_q;
            rdata[sync_pkg::ST_STOP_BIT] <= stop_sync_q;
            rdata[sync_pkg::ST_COUNT_LSB +: 3] <= count_of(member_q);
          end
          sync_pkg::IRQ_STAT_ADDR: rdata <= 32'(irq_stat_q);
          sync_pkg::IRQ_MASK_ADDR: rdata <= 32'(irq_mask_q);
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // checks
  sync_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce [*2] ##0 $past(!shared_start_line_in_n, 2) |-> start_sync_q)
    else $error("start line not seen two cycles later");
  stop_line_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && stop_sync_q && cfg_q[0].stop_enable && axis_busy[0] |=> stop_now[0] || stop_ramp[0])
    else $error("enabled axis ignored stop line");
  lead_check_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr && addr == sync_pkg::CMD_ADDR && wdata[sync_pkg::CMD_GSTART_BIT]
    && wdata[sync_pkg::CMD_LEAD_LSB +: 2] != lead_of(member_q) |=> shared_start_line_oe_n)
    else $error("group start by non-lead axis");
  start_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && gstart_cmd ##1 ce [*2] |-> !shared_start_line_oe_n)
    else $error("group start not driven on line");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && |(irq_evt & irq_mask_q) && !(wr && addr == sync_pkg::IRQ_MASK_ADDR) |=> irq)
    else $error("interrupt level wrong");
  cover_gstart_c: cover property (@(posedge ref_clk) gstart_cmd ##[1:6] |start_pulse);
  cover_gstop_c: cover property (@(posedge ref_clk) gstop_cmd ##[1:6] |stop_ramp);

endmodule

// file: verilog/sync_pkg.sv
/*
  constants, field layouts and types shared by the multi-axis start/stop
  synchronisation block and its per-axis controller.
  assumes one 10 MHz clock and wired-low shared start/stop lines.
*/
// ==========================================================================
package sync_pkg;

  localparam int NUM_AXES = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ========================================================================
  // register map, byte addresses
  localparam logic [7:0] CFG_BASE = 8'h00; // axis n config at CFG_BASE + 4n
  localparam logic [7:0] CMD_ADDR = 8'h10;
  localparam logic [7:0] GROUP_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h1C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h20;

  // ========================================================================
  // field positions
  localparam int CFG_W = 9;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_GSTART_BIT = 4;
  localparam int CMD_GSTOP_BIT = 5;
  localparam int CMD_LEAD_LSB = 8;
  localparam int ST_WAIT_LSB = 0;
  localparam int ST_BUSY_LSB = 4;
  localparam int ST_DRIVE_LSB = 8;
  localparam int ST_START_BIT = 12;
  localparam int ST_STOP_BIT = 13;
  localparam int ST_COUNT_LSB = 16;
  localparam int IRQ_W = 8; // [3:0] axis started, [7:4] abnormal stop

  // ========================================================================
  // reset values and encodings
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam logic [3:0] GROUP_RESET = 4'h0;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [1:0] START_NOW = 2'h0;
  localparam logic [1:0] START_GROUP = 2'h1;
  localparam logic [1:0] START_RSVD = 2'h2;
  localparam logic [1:0] START_AXES = 2'h3;

  // ========================================================================
  // timing: width of a pulse this block drives onto a shared line
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINE_PULSE_NS = 1000;
  localparam int LINE_PULSE_CYC = (LINE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic stop_mode;         // 0 immediate, 1 decelerate
    logic [1:0] start_type;  // start_type_select
    logic auto_stop_out;     // drive stop line on abnormal stop
    logic stop_enable;       // respond to shared stop line
    logic [3:0] wait_mask;   // wait_axis_mask
  } axis_cfg_type;

  typedef enum logic [1:0] {idle_st, wait_start_st, wait_axes_st} axis_state_type;

endpackage
